//--- hdl/irq_route_consts.svh
`ifndef IRQ_ROUTE_CONSTS_SVH
`define IRQ_ROUTE_CONSTS_SVH

// ----------------------------------------------------------------------
// Source and line counts
// ----------------------------------------------------------------------
`define NUM_SRC 174
`define SRC_IDX_W 8
`define NUM_SEC_LINES 8
`define SEC_LINE_W 3
`define SEC_SYS_LINE 3'h0
`define NUM_SEC_SW 8
`define MAIN_PRIO_W 3
`define SEC_PRIO_W 2
`define NMI_SLOTS 4
`define NUM_WAKE_SRC 39

// ----------------------------------------------------------------------
// Interprocessor block
// ----------------------------------------------------------------------
`define NUM_CHAN 16
`define CHAN_W 4
`define NUM_SYS_CHAN 5'h08
`define DATA_W 32
`define NUM_CORES 2

`endif

//--- hdl/irq_route_pkg.sv
`include "irq_route_consts.svh"

package irq_route_pkg;

    // ------------------------------------------------------------------
    // Interprocessor channel operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ACQUIRE,
        OP_RELEASE,
        OP_WRITE,
        OP_READ,
        OP_NOTIFY
    } ipc_op_t;

    // ------------------------------------------------------------------
    // State of the router, except the channel data words held in the data store
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`NUM_SRC-1:0] main_irq;
        logic [`NUM_SEC_LINES-1:0] sec_irq;
        logic [`NUM_SEC_SW-1:0] sw_pend;
        logic [`MAIN_PRIO_W-1:0] main_top;
        logic main_any;
        logic [`SEC_PRIO_W-1:0] sec_top;
        logic sec_any;
        logic [`NUM_CORES-1:0] nmi;
        logic wake;
        logic [`NUM_CHAN-1:0] lock_held;
        logic [`NUM_CHAN-1:0] lock_owner;
        logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] notify_pend;
        logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] release_pend;
        logic [`NUM_CORES-1:0] ack;
        logic ok;
    } route_state_t;

endpackage

//--- hdl/ipc_mem_if.sv
`include "irq_route_consts.svh"

// Carries one access at a time into the channel data store
interface ipc_mem_if;
    logic we;
    logic [`CHAN_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [`DATA_W-1:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

//--- hdl/ipc_data_mem.sv
`include "irq_route_consts.svh"

// ----------------------------------------------------------------------
// Channel data words, one per channel, read data from a flip-flop
// ----------------------------------------------------------------------
module ipc_data_mem (
    input wire logic clock,
    input wire logic srst,
    ipc_mem_if.mem bus
);
    typedef struct packed {
        logic [`NUM_CHAN-1:0][`DATA_W-1:0] word;
        logic [`DATA_W-1:0] rdata;
    } mem_state_t;

    mem_state_t state_reg;
    mem_state_t state_next;

    // Read returns the old word on a same-cycle write
    always_comb begin
        state_next = state_reg;
        state_next.rdata = state_reg.word[bus.addr];
        if (bus.we) begin
            state_next.word[bus.addr] = bus.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.rdata = state_reg.rdata;
endmodule // ipc_data_mem

//--- hdl/irq_route.sv
`include "irq_route_consts.svh"

module irq_route
    import irq_route_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    // Interrupt sources and routing configuration
    input wire logic [`NUM_SRC-1:0] irq_src,
    input wire logic [`NUM_SRC-1:0] sec_map_en,
    input wire logic [`NUM_SRC-1:0][`SEC_LINE_W-1:0] sec_map_line,
    input wire logic sec_sys_src,
    input wire logic [`NUM_SEC_SW-1:0] sec_sw_set,
    input wire logic [`NUM_SEC_SW-1:0] sec_sw_clr,
    input wire logic [`NUM_SRC-1:0][`MAIN_PRIO_W-1:0] main_prio,
    input wire logic [`NUM_SEC_LINES+`NUM_SEC_SW-1:0][`SEC_PRIO_W-1:0] sec_prio,
    input wire logic [`NUM_CORES-1:0][`NMI_SLOTS-1:0] nmi_sel_en,
    input wire logic [`NUM_CORES-1:0][`NMI_SLOTS-1:0][`SRC_IDX_W-1:0] nmi_sel_src,
    input wire logic [`NUM_CORES-1:0] sysfn_req_core,
    input wire logic sysfn_req_debug,
    input wire logic [`NUM_WAKE_SRC-1:0] wake_en,
    // Interrupt outputs
    output logic [`NUM_SRC-1:0] main_irq,
    output logic [`NUM_SEC_LINES-1:0] sec_irq,
    output logic [`NUM_SEC_SW-1:0] sec_sw_irq,
    output logic [`MAIN_PRIO_W-1:0] main_top_prio,
    output logic main_any,
    output logic [`SEC_PRIO_W-1:0] sec_top_prio,
    output logic sec_any,
    output logic [`NUM_CORES-1:0] nmi,
    output logic wake_req,
    // Interprocessor channel access, one port per core
    input wire logic [`NUM_CORES-1:0] ipc_req,
    input wire ipc_op_t [`NUM_CORES-1:0] ipc_op,
    input wire logic [`NUM_CORES-1:0][`CHAN_W-1:0] ipc_chan,
    input wire logic [`NUM_CORES-1:0][`DATA_W-1:0] ipc_wdata,
    input wire logic [`NUM_CORES-1:0] ipc_priv,
    output logic [`NUM_CORES-1:0] ipc_ready,
    output logic [`NUM_CORES-1:0] ipc_ack,
    output logic ipc_ok,
    output logic [`DATA_W-1:0] ipc_rdata,
    output logic [`NUM_CHAN-1:0] lock_held,
    output logic [`NUM_CHAN-1:0] lock_owner,
    input wire logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_irq_clr,
    output logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_notify_irq,
    output logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_release_irq,
    output logic [`NUM_CORES-1:0] ipc_irq
);

    // ------------------------------------------------------------------
    // State, data store and arbitration
    // ------------------------------------------------------------------
    route_state_t state_reg;
    route_state_t state_next;
    ipc_mem_if mem_bus ();

    ipc_data_mem u_mem (
        .clock(clock),
        .srst(srst),
        .bus(mem_bus)
    );

    // Core 0 wins a same-cycle clash; core 1 simply holds its request
    logic sel;
    logic go;
    logic [`CHAN_W-1:0] chan;
    ipc_op_t op;
    logic allowed;

    assign ipc_ready[0] = 1'b1;
    assign ipc_ready[1] = !ipc_req[0];
    assign sel = !ipc_req[0];
    assign go = ipc_req[0] | ipc_req[1];
    assign chan = ipc_chan[sel];
    assign op = ipc_op[sel];
    // Low channels belong to system code; unprivileged access is refused
    assign allowed = ipc_priv[sel] || ({1'b0, chan} >= `NUM_SYS_CHAN);

    assign mem_bus.addr = chan;
    assign mem_bus.wdata = ipc_wdata[sel];
    assign mem_bus.we = go && allowed && op == OP_WRITE;

    // ------------------------------------------------------------------
    // Secondary line mapping, separate so the loop stays readable
    // ------------------------------------------------------------------
    logic [`NUM_SEC_LINES-1:0] line_or;

    always_comb begin
        line_or = '0;
        for (int s = 0; s < `NUM_SRC; s++) begin
            // Any mapped active source raises its line; line 0 is skipped
            if (irq_src[s] && sec_map_en[s] && sec_map_line[s] != `SEC_SYS_LINE) begin
                line_or[sec_map_line[s]] = 1'b1;
            end
        end
        line_or[`SEC_SYS_LINE] = sec_sys_src;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [`NUM_SEC_LINES+`NUM_SEC_SW-1:0] sec_all;

    always_comb begin
        state_next = state_reg;
        // Main lines a straight copy, secondary lines from the mapping, one register stage
        state_next.main_irq = irq_src;
        state_next.sec_irq = line_or;

        // Software interrupts: a set in the clearing cycle is kept
        state_next.sw_pend = (state_reg.sw_pend & ~sec_sw_clr) | sec_sw_set;

        // Highest level among active sources, smaller number wins
        state_next.main_any = 1'b0;
        state_next.main_top = '1;
        for (int s = 0; s < `NUM_SRC; s++) begin
            if (irq_src[s] && (!state_next.main_any || main_prio[s] < state_next.main_top)) begin
                state_next.main_top = main_prio[s];
                state_next.main_any = 1'b1;
            end
        end
        sec_all = {state_reg.sw_pend, line_or};
        state_next.sec_any = 1'b0;
        state_next.sec_top = '1;
        for (int l = 0; l < `NUM_SEC_LINES + `NUM_SEC_SW; l++) begin
            if (sec_all[l] && (!state_next.sec_any || sec_prio[l] < state_next.sec_top)) begin
                state_next.sec_top = sec_prio[l];
                state_next.sec_any = 1'b1;
            end
        end

        // Non-maskable inputs; out-of-range selections never fire
        for (int c = 0; c < `NUM_CORES; c++) begin
            state_next.nmi[c] = 1'b0;
            for (int k = 0; k < `NMI_SLOTS; k++) begin
                if (nmi_sel_en[c][k] && nmi_sel_src[c][k] < `SRC_IDX_W'(`NUM_SRC)) begin
                    state_next.nmi[c] = state_next.nmi[c] | irq_src[nmi_sel_src[c][k]];
                end
            end
        end
        // Any system-function request forces the secondary NMI
        if (|sysfn_req_core || sysfn_req_debug) begin
            state_next.nmi[1] = 1'b1;
        end

        // Only the low wake-capable sources reach the wakeup controller
        state_next.wake = |(irq_src[`NUM_WAKE_SRC-1:0] & wake_en);

        // Channel operations, answered one cycle later
        state_next.ack = '0;
        state_next.ok = 1'b0;
        if (go) begin
            state_next.ack[sel] = 1'b1;
            if (allowed) begin
                unique case (op)
                    OP_ACQUIRE: begin
                        // Grant only a free lock; a second try by the owner also succeeds
                        if (!state_reg.lock_held[chan] || state_reg.lock_owner[chan] == sel) begin
                            state_next.lock_held[chan] = 1'b1;
                            state_next.lock_owner[chan] = sel;
                            state_next.ok = 1'b1;
                        end
                    end
                    OP_RELEASE: begin
                        // Only the owner may release; the other core is told
                        if (state_reg.lock_held[chan] && state_reg.lock_owner[chan] == sel) begin
                            state_next.lock_held[chan] = 1'b0;
                            state_next.release_pend[!sel][chan] = 1'b1;
                            state_next.ok = 1'b1;
                        end
                    end
                    OP_WRITE, OP_READ: begin
                        state_next.ok = 1'b1;
                    end
                    OP_NOTIFY: begin
                        state_next.notify_pend[!sel][chan] = 1'b1;
                        state_next.ok = 1'b1;
                    end
                    default: begin
                        state_next.ok = 1'b0;
                    end
                endcase
            end
        end

        // Clearing by the target core; a set in the same cycle wins unless the bit was already pending
        for (int c = 0; c < `NUM_CORES; c++) begin
            state_next.notify_pend[c] = state_next.notify_pend[c]
                & ~(ipc_irq_clr[c] & ~(state_next.notify_pend[c] & ~state_reg.notify_pend[c]));
            state_next.release_pend[c] = state_next.release_pend[c]
                & ~(ipc_irq_clr[c] & ~(state_next.release_pend[c] & ~state_reg.release_pend[c]));
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from the state register except ipc_rdata, from the data store's register, and ipc_ready, tied high for core 0 and set from ipc_req[0] for core 1
    // ------------------------------------------------------------------
    assign main_irq = state_reg.main_irq;
    assign sec_irq = state_reg.sec_irq;
    assign sec_sw_irq = state_reg.sw_pend;
    assign main_top_prio = state_reg.main_top;
    assign main_any = state_reg.main_any;
    assign sec_top_prio = state_reg.sec_top;
    assign sec_any = state_reg.sec_any;
    assign nmi = state_reg.nmi;
    assign wake_req = state_reg.wake;
    assign ipc_ack = state_reg.ack;
    assign ipc_ok = state_reg.ok;
    assign ipc_rdata = mem_bus.rdata;
    assign lock_held = state_reg.lock_held;
    assign lock_owner = state_reg.lock_owner;
    assign ipc_notify_irq = state_reg.notify_pend;
    assign ipc_release_irq = state_reg.release_pend;

    // One summary line per core over the notify and release bits of all sixteen channels
    genvar g;
    generate
        for (g = 0; g < `NUM_CORES; g++) begin : g_ipc_irq
            assign ipc_irq[g] = |(state_reg.notify_pend[g] | state_reg.release_pend[g]);
        end
    endgenerate
endmodule // irq_route

//--- dv/irq_route_sva.sv
`include "irq_route_consts.svh"

module irq_route_sva
    import irq_route_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [`NUM_SRC-1:0] irq_src,
    input wire logic [`NUM_SRC-1:0] sec_map_en,
    input wire logic [`NUM_SRC-1:0][`SEC_LINE_W-1:0] sec_map_line,
    input wire logic sec_sys_src,
    input wire logic [`NUM_SEC_SW-1:0] sec_sw_set,
    input wire logic [`NUM_SEC_SW-1:0] sec_sw_clr,
    input wire logic [`NUM_CORES-1:0] sysfn_req_core,
    input wire logic sysfn_req_debug,
    input wire logic [`NUM_WAKE_SRC-1:0] wake_en,
    input wire logic [`NUM_SRC-1:0] main_irq,
    input wire logic [`NUM_SEC_LINES-1:0] sec_irq,
    input wire logic [`NUM_SEC_SW-1:0] sec_sw_irq,
    input wire logic [`NUM_CORES-1:0] nmi,
    input wire logic wake_req,
    input wire logic [`NUM_CORES-1:0] ipc_req,
    input wire ipc_op_t [`NUM_CORES-1:0] ipc_op,
    input wire logic [`NUM_CORES-1:0][`CHAN_W-1:0] ipc_chan,
    input wire logic [`NUM_CORES-1:0] ipc_priv,
    input wire logic [`NUM_CORES-1:0] ipc_ready,
    input wire logic [`NUM_CORES-1:0] ipc_ack,
    input wire logic ipc_ok,
    input wire logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_notify_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // Expected secondary lines; mappings onto line 0 are dropped
    logic [`NUM_SEC_LINES-1:0] sec_exp;
    always_comb begin
        sec_exp = {{(`NUM_SEC_LINES-1){1'b0}}, sec_sys_src};
        for (int s = 0; s < `NUM_SRC; s++) begin
            if (sec_map_en[s] && irq_src[s] && sec_map_line[s] != 3'h0) begin
                sec_exp[sec_map_line[s]] = 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    AST_MAIN_DIRECT: assert property (!$past(srst) |-> main_irq == $past(irq_src))
        else $error("main lines differ from sources");
    AST_SEC_MAP: assert property (!$past(srst) |-> sec_irq == $past(sec_exp))
        else $error("secondary lines differ from mapping");
    AST_SW_NEXT: assert property (!$past(srst)
        |-> sec_sw_irq == ($past(sec_sw_set) | ($past(sec_sw_irq) & ~$past(sec_sw_clr))))
        else $error("software interrupt state wrong");
    AST_IPC_ACK: assert property (ipc_req[0] |=> ipc_ack[0] && !ipc_ack[1])
        else $error("core 0 request not acknowledged");
    AST_ACK_CAUSE: assert property (ipc_ack[1] |-> $past(ipc_req[1] && ipc_ready[1]))
        else $error("core 1 ack without accepted request");
    AST_RESERVED: assert property (ipc_req[0] && ipc_chan[0] < `NUM_SYS_CHAN && !ipc_priv[0] |=> !ipc_ok)
        else $error("reserved channel accepted without privilege");
    AST_NOTIFY: assert property (ipc_req[0] && ipc_op[0] == OP_NOTIFY && ipc_chan[0] >= 4'h8
        |=> ipc_ok && ipc_notify_irq[1][$past(ipc_chan[0])])
        else $error("notify did not reach core 1");
    AST_SYSFN_NMI: assert property ((|sysfn_req_core) || sysfn_req_debug |=> nmi[1])
        else $error("system function request gave no nmi");
    AST_WAKE: assert property ((|(irq_src[`NUM_WAKE_SRC-1:0] & wake_en)) |=> wake_req)
        else $error("enabled wake source gave no wake request");

    // Main scenarios reached
    cover property (ipc_ack[0] && ipc_ok);
    cover property (|ipc_notify_irq[1]);
    cover property (nmi[1]);
endmodule // irq_route_sva

bind irq_route irq_route_sva irq_route_sva_i (.clock, .srst, .irq_src, .sec_map_en, .sec_map_line, .sec_sys_src,
    .sec_sw_set, .sec_sw_clr, .sysfn_req_core, .sysfn_req_debug, .wake_en, .main_irq, .sec_irq, .sec_sw_irq, .nmi,
    .wake_req, .ipc_req, .ipc_op, .ipc_chan, .ipc_priv, .ipc_ready, .ipc_ack, .ipc_ok, .ipc_notify_irq);

//--- dv/core_handler_model.sv
`include "irq_route_consts.svh"

module core_handler_model #(
    parameter int DELAY = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [`NUM_CORES-1:0] ipc_irq,
    input wire logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_notify_irq,
    input wire logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_release_irq,
    output logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_irq_clr
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt [`NUM_CORES];

    initial ipc_irq_clr = '0;

    // Each core services its pending events after a handler delay; a slow handler shows stickiness
    always @(posedge clock) begin
        for (int c = 0; c < `NUM_CORES; c++) begin
            if (srst || !ipc_irq[c]) begin
                ipc_irq_clr[c] <= '0;
                wait_cnt[c] <= 0;
            end else if (wait_cnt[c] == DELAY) begin
                ipc_irq_clr[c] <= ipc_notify_irq[c] | ipc_release_irq[c];
                wait_cnt[c] <= 0;
            end else begin
                ipc_irq_clr[c] <= '0;
                wait_cnt[c] <= wait_cnt[c] + 1;
            end
        end
    end
endmodule // core_handler_model

//--- dv/irq_route_tb.sv
`include "irq_route_consts.svh"

module irq_route_tb
    import irq_route_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [`NUM_SRC-1:0] irq_src = '0, sec_map_en = '0, main_irq;
    logic [`NUM_SRC-1:0][`SEC_LINE_W-1:0] sec_map_line = '0;
    logic sec_sys_src = 1'b0, sysfn_req_debug = 1'b0, wake_req, main_any, sec_any, ipc_ok;
    logic [`NUM_SEC_SW-1:0] sec_sw_set = '0, sec_sw_clr = '0, sec_sw_irq;
    logic [`NUM_SEC_LINES-1:0] sec_irq;
    logic [`NUM_SRC-1:0][`MAIN_PRIO_W-1:0] main_prio = '1;
    logic [`NUM_SEC_LINES+`NUM_SEC_SW-1:0][`SEC_PRIO_W-1:0] sec_prio = '1;
    logic [`NUM_CORES-1:0][`NMI_SLOTS-1:0] nmi_sel_en = '0;
    logic [`NUM_CORES-1:0][`NMI_SLOTS-1:0][`SRC_IDX_W-1:0] nmi_sel_src = '0;
    logic [`NUM_CORES-1:0] sysfn_req_core = '0, ipc_req = '0, ipc_priv = '0, nmi, ipc_ready, ipc_ack, ipc_irq;
    logic [`NUM_WAKE_SRC-1:0] wake_en = '0;
    logic [`MAIN_PRIO_W-1:0] main_top_prio;
    logic [`SEC_PRIO_W-1:0] sec_top_prio;
    ipc_op_t [`NUM_CORES-1:0] ipc_op = {OP_READ, OP_READ};
    logic [`NUM_CORES-1:0][`CHAN_W-1:0] ipc_chan = '0;
    logic [`NUM_CORES-1:0][`DATA_W-1:0] ipc_wdata = '0;
    logic [`DATA_W-1:0] ipc_rdata;
    logic [`NUM_CHAN-1:0] lock_held, lock_owner;
    logic [`NUM_CORES-1:0][`NUM_CHAN-1:0] ipc_irq_clr, ipc_notify_irq, ipc_release_irq;
    int fail_count = 0, checks_done = 0, cycles = 0;

    always #2.5 clock = ~clock;

    irq_route irq_route_i (.clock, .srst, .irq_src, .sec_map_en, .sec_map_line, .sec_sys_src, .sec_sw_set,
        .sec_sw_clr, .main_prio, .sec_prio, .nmi_sel_en, .nmi_sel_src, .sysfn_req_core, .sysfn_req_debug, .wake_en,
        .main_irq, .sec_irq, .sec_sw_irq, .main_top_prio, .main_any, .sec_top_prio, .sec_any, .nmi, .wake_req,
        .ipc_req, .ipc_op, .ipc_chan, .ipc_wdata, .ipc_priv, .ipc_ready, .ipc_ack, .ipc_ok, .ipc_rdata, .lock_held,
        .lock_owner, .ipc_irq_clr, .ipc_notify_irq, .ipc_release_irq, .ipc_irq);
    core_handler_model #(.DELAY(4)) core_handler_model_i (.clock, .srst, .ipc_irq, .ipc_notify_irq,
        .ipc_release_irq, .ipc_irq_clr);

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Request held until the edge that takes it; ack and ok land with that same edge
    task automatic ipc(input int c, input ipc_op_t op, input int ch, input logic [31:0] wd, input logic pv,
                       input logic ok_exp);
        @(posedge clock);
        ipc_req[c] <= 1'b1;
        ipc_op[c] <= op;
        ipc_chan[c] <= 4'(ch);
        ipc_wdata[c] <= wd;
        ipc_priv[c] <= pv;
        @(posedge clock);
        while (ipc_ready[c] !== 1'b1) @(posedge clock);
        ipc_req[c] <= 1'b0;
        #1;
        chk(ipc_ack[c], 1'b1);
        chk(ipc_ok, ok_exp);
    endtask

    task automatic complete_run();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_route();
        @(posedge clock);
        sec_map_en[7:5] <= 3'b111;
        sec_map_line[5] <= 3'h3;
        sec_map_line[6] <= 3'h3;
        irq_src[7:5] <= 3'b111;
        irq_src[173] <= 1'b1;
        main_prio[5] <= 3'h2;
        sec_prio[3] <= 2'h1;
        cyc(3);
        chk(main_irq[31:0], 32'h0000_00e0);
        chk(main_irq[173:142], 32'h8000_0000);
        chk(sec_irq, 8'h08);
        chk({main_any, main_top_prio}, 4'ha);
        chk({sec_any, sec_top_prio}, 3'h5);
        irq_src[5] <= 1'b0;
        sec_sys_src <= 1'b1;
        cyc(3);
        chk(sec_irq, 8'h09);
        chk({main_any, main_top_prio}, 4'hf);
        irq_src <= '0;
        sec_sys_src <= 1'b0;
    endtask

    task automatic t_sw();
        @(posedge clock);
        sec_sw_set <= 8'hff;
        sec_sw_clr <= 8'h04;
        // Set and clear taken together: the set must win
        @(posedge clock);
        sec_sw_set <= 8'h00;
        sec_sw_clr <= 8'h00;
        #1;
        chk(sec_sw_irq, 8'hff);
        chk(sec_irq, 8'h00);
        // A cycle with neither strobe: the bits must stick
        @(posedge clock);
        sec_sw_clr <= 8'hff;
        #1;
        chk(sec_sw_irq, 8'hff);
        @(posedge clock);
        sec_sw_clr <= 8'h00;
        cyc(2);
        chk(sec_sw_irq, 8'h00);
    endtask

    task automatic t_nmi();
        @(posedge clock);
        nmi_sel_en[0][3] <= 1'b1;
        nmi_sel_src[0][3] <= 8'd38;
        nmi_sel_en[1][0] <= 1'b1;
        nmi_sel_src[1][0] <= 8'd174;
        wake_en[38] <= 1'b1;
        irq_src[38] <= 1'b1;
        cyc(3);
        chk(nmi, 2'b01);
        chk(wake_req, 1'b1);
        wake_en[38] <= 1'b0;
        cyc(3);
        chk(wake_req, 1'b0);
        irq_src[38] <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            {sysfn_req_debug, sysfn_req_core} <= 3'(1 << k);
            @(posedge clock);
            {sysfn_req_debug, sysfn_req_core} <= 3'h0;
            #1;
            chk(nmi[1], 1'b1);
        end
    endtask

    task automatic t_ipc();
        ipc(0, OP_ACQUIRE, 9, 0, 0, 1);
        chk({lock_held[9], lock_owner[9]}, 2'b10);
        ipc(1, OP_ACQUIRE, 9, 0, 0, 0);
        ipc(0, OP_NOTIFY, 9, 0, 0, 1);
        chk({ipc_notify_irq[1][9], ipc_irq[1]}, 2'b11);
        ipc(0, OP_WRITE, 15, 32'hcafe_0f0f, 0, 1);
        ipc(1, OP_READ, 15, 0, 0, 1);
        chk(ipc_rdata, 32'hcafe_0f0f);
        ipc(1, OP_WRITE, 2, 32'h1, 0, 0);
        ipc(1, OP_READ, 2, 0, 1, 1);
        chk(ipc_rdata, 32'h0);
        ipc(0, OP_ACQUIRE, 3, 0, 0, 0);
        chk(lock_held[3], 1'b0);
        // Same-cycle clash: core 1 must wait one cycle for ready
        fork
            ipc(0, OP_WRITE, 10, 32'h0000_a5a5, 0, 1);
            ipc(1, OP_WRITE, 11, 32'h0000_5a5a, 0, 1);
        join
        ipc(0, OP_READ, 11, 0, 0, 1);
        chk(ipc_rdata, 32'h0000_5a5a);
        ipc(1, OP_NOTIFY, 12, 0, 0, 1);
        chk({ipc_notify_irq[0][12], ipc_irq[0]}, 2'b11);
        ipc(0, OP_RELEASE, 9, 0, 0, 1);
        chk({lock_held[9], ipc_release_irq[1][9]}, 2'b01);
        cyc(8);
        chk(ipc_irq, 2'b00);
    endtask

    // Hang guard, far above the roughly 64 cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        cyc(3);
        srst <= 1'b0;
        t_route();
        t_sw();
        t_nmi();
        t_ipc();
        cyc(2);
        complete_run();
    end
endmodule // irq_route_tb
